/* inc/clk_sel_pkg.sv */
// constants and types for the interface clock source select block
// Contract
// - seven gate bits, 27 down to 21, one per interface clock domain
// - gate bit 0 passes the selected pll clock, 1 holds it off
// - 3-bit source field per domain: 0 if,1 app,2 sys,3 disp,4 mem pll
// - reset loads 0x1800: gates clear, app domain app pll, mem domain mem pll
package clk_sel_pkg;
  localparam int NUM_DOMAINS = 7;
  localparam int NUM_PLLS = 5;
  localparam int SEL_W = 3;
  localparam int ADDR_W = 12;
  localparam int GATE_LSB = 21;
  localparam int GATE_MSB = 27;
  localparam int SEL_MSB = 20;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h0f8;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h200;
  localparam logic [31:0] CTRL_RESET = 32'h0000_1800;
  localparam logic [31:0] CTRL_MASK = 32'h0fff_ffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // domain order follows the field order, domain 0 in the low bits
  typedef enum logic [2:0] {
    SRC_INTERFACE_PLL = 3'h0,
    SRC_APPLICATION_PLL = 3'h1,
    SRC_SYSTEM_PLL = 3'h2,
    SRC_DISPLAY_PLL = 3'h3,
    SRC_MEMORY_PLL = 3'h4
  } pll_source_t;

  typedef struct packed {
    logic [NUM_DOMAINS-1:0] hold;
    logic [NUM_DOMAINS*SEL_W-1:0] source;
  } domain_ctrl_t;
endpackage

/* verilog/interface_clock_source_select.sv */
// axi4-lite register and per-domain pll source mux with clock hold
`timescale 1ns/1ps
`default_nettype none
module interface_clock_source_select (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [clk_sel_pkg::NUM_PLLS-1:0] pll_tick,
  output logic [clk_sel_pkg::NUM_DOMAINS-1:0] domain_tick,
  output clk_sel_pkg::domain_ctrl_t domain_ctrl,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [clk_sel_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [clk_sel_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  localparam int ND = clk_sel_pkg::NUM_DOMAINS;
  localparam int SW = clk_sel_pkg::SEL_W;

  logic [31:0] ctrl;
  logic [ND-1:0] gate;
  logic [ND-1:0] next_tick;
  logic [ND-1:0] live;
  logic [clk_sel_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic aw_got;
  logic w_got;
  logic do_write;
  logic first_cycle;

  // routes one pll tick by source code; unused codes route none
  function automatic logic route(input logic [SW-1:0] code,
                                 input logic [clk_sel_pkg::NUM_PLLS-1:0] t);
    case (code)
      clk_sel_pkg::SRC_INTERFACE_PLL: route = t[0];
      clk_sel_pkg::SRC_APPLICATION_PLL: route = t[1];
      clk_sel_pkg::SRC_SYSTEM_PLL: route = t[2];
      clk_sel_pkg::SRC_DISPLAY_PLL: route = t[3];
      clk_sel_pkg::SRC_MEMORY_PLL: route = t[4];
      default: route = 1'b0;
    endcase
  endfunction

  // merges write data under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic logic [SW-1:0] src_of(input logic [31:0] w,
                                           input int i);
    src_of = w[SW*i +: SW];
  endfunction

  assign gate = ctrl[clk_sel_pkg::GATE_MSB:clk_sel_pkg::GATE_LSB];
  assign domain_ctrl.hold = gate;
  assign domain_ctrl.source = ctrl[clk_sel_pkg::SEL_MSB:0];
  assign do_write = aw_got && w_got && !s_axi_bvalid;

  // per-domain mux and hold
  always_comb begin
    next_tick = '0;
    live = '0;
    for (int i = 0; i < ND; i++) begin
      live[i] = !gate[i] && (src_of(ctrl, i) <= SW'(clk_sel_pkg::NUM_PLLS - 1));
      next_tick[i] = !gate[i] && route(src_of(ctrl, i), pll_tick);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      domain_tick <= '0;
    end else begin
      domain_tick <= next_tick;
    end
  end

  // control word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= clk_sel_pkg::CTRL_RESET;
    end else if (do_write && wr_addr == clk_sel_pkg::CTRL_ADDR) begin
      ctrl <= merge(ctrl, wr_data, wr_strb) & clk_sel_pkg::CTRL_MASK;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end

  // write address channel
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      aw_got <= 1'b0;
      wr_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_got <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_wready <= 1'b1;
      w_got <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_got <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= clk_sel_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_addr == clk_sel_pkg::CTRL_ADDR) ?
                     clk_sel_pkg::RESP_OKAY : clk_sel_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= clk_sel_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= clk_sel_pkg::RESP_OKAY;
      if (s_axi_araddr == clk_sel_pkg::CTRL_ADDR) begin
        s_axi_rdata <= ctrl;
      end else if (s_axi_araddr == clk_sel_pkg::STATUS_ADDR) begin
        s_axi_rdata <= {25'h0, live};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= clk_sel_pkg::RESP_DECERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence write_ctrl_s;
    do_write && wr_addr == clk_sel_pkg::CTRL_ADDR;
  endsequence

  sequence ctrl_answered_s;
    s_axi_bvalid && s_axi_bresp == clk_sel_pkg::RESP_OKAY;
  endsequence

  sequence read_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence

  sequence read_ctrl_s;
    s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == clk_sel_pkg::CTRL_ADDR;
  endsequence

  sequence read_status_s;
    s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == clk_sel_pkg::STATUS_ADDR;
  endsequence

  a_reset_word_loaded:
    assert property (first_cycle |->
      ctrl == clk_sel_pkg::CTRL_RESET && gate == '0)
    else $error("control word not at reset value");

  a_write_sets_word:
    assert property (write_ctrl_s |=> ctrl_answered_s and
      (ctrl == (merge($past(ctrl), $past(wr_data), $past(wr_strb))
                & clk_sel_pkg::CTRL_MASK)))
    else $error("control write not applied");

  a_read_shows_word:
    assert property (read_ctrl_s |=>
      s_axi_rvalid && s_axi_rdata == $past(ctrl))
    else $error("control readback wrong");

  a_status_shows_live:
    assert property (read_status_s |=>
      s_axi_rvalid && s_axi_rdata == {25'h0, $past(live)} &&
      s_axi_rresp == clk_sel_pkg::RESP_OKAY)
    else $error("status readback wrong");

  a_unmapped_read:
    assert property (read_taken_s and
      (s_axi_araddr != clk_sel_pkg::CTRL_ADDR &&
       s_axi_araddr != clk_sel_pkg::STATUS_ADDR) |=>
      s_axi_rvalid && s_axi_rdata == '0 &&
      s_axi_rresp == clk_sel_pkg::RESP_DECERR)
    else $error("unmapped read not refused");

  a_unmapped_write:
    assert property (do_write && wr_addr != clk_sel_pkg::CTRL_ADDR |=>
      s_axi_bvalid && s_axi_bresp == clk_sel_pkg::RESP_DECERR &&
      $stable(ctrl))
    else $error("unmapped write not refused");

  a_ctrl_steady:
    assert property (!(do_write && wr_addr == clk_sel_pkg::CTRL_ADDR) |=>
      $stable(ctrl))
    else $error("control word changed without a write");

  a_reserved_clear:
    assert property ((ctrl & ~clk_sel_pkg::CTRL_MASK) == '0)
    else $error("reserved control bits set");

  a_bvalid_holds:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  a_rvalid_holds:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response dropped early");

  a_aw_refused:
    assert property (aw_got |-> !s_axi_awready)
    else $error("write address taken twice");

  a_w_refused:
    assert property (w_got |-> !s_axi_wready)
    else $error("write data taken twice");

  a_ar_refused:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");

  a_gate_blocks_tick:
    assert property (1'b1 |=> (domain_tick & $past(gate)) == '0)
    else $error("gated domain produced a tick");

  for (genvar g = 0; g < ND; g++) begin : g_chk
    a_open_passes_pll:
      assert property (!gate[g] &&
        src_of(ctrl, g) <= clk_sel_pkg::SRC_MEMORY_PLL &&
        route(src_of(ctrl, g), pll_tick) |=> domain_tick[g])
      else $error("selected pll tick not passed");
    a_tick_has_source:
      assert property (1'b1 |=> !domain_tick[g] ||
        (!$past(gate[g]) && $past(route(src_of(ctrl, g), pll_tick))))
      else $error("domain tick without selected pll tick");
    a_unused_code_silent:
      assert property (src_of(ctrl, g) > clk_sel_pkg::SRC_MEMORY_PLL |=>
        !domain_tick[g])
      else $error("unused source code passed a tick");
  end
endmodule // interface_clock_source_select
`default_nettype wire

/* verification/interface_clock_source_select_tb_top.sv */
// self-checking bench for the clock source select block
`timescale 1ns/1ps
`default_nettype none
module interface_clock_source_select_tb_top;
  logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [4:0] pll_tick;
  logic [6:0] domain_tick;
  clk_sel_pkg::domain_ctrl_t domain_ctrl;
  int fails, tests_run;
  int cyc = 0;
  interface_clock_source_select i_dut (.clk(clk), .arst_n(arst_n),
    .pll_tick(pll_tick), .domain_tick(domain_tick),
    .domain_ctrl(domain_ctrl), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic finish_test;
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      fails++;
      finish_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    chk(rdata, exp);
    rready <= 0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic [4:0] t, input logic [6:0] e);
    pll_tick <= t;
    @(posedge clk);
    pll_tick <= 5'h00;
    #1 chk({25'h0, domain_tick}, {25'h0, e});
    @(posedge clk);
  endtask
  task automatic t_reset;
    chk({4'h0, domain_ctrl}, 32'h0000_1800);
    rd(clk_sel_pkg::CTRL_ADDR, 32'h0000_1800);
    rd(12'h200, 32'h0000_007f);
    $display("done reset");
  endtask
  task automatic t_route;
    wr(12'h0f8, 32'h0fe0_1800);
    wr(12'h0f8, 32'h0fe0_0000);
    wr(12'h0f8, 32'h0000_0000);
    for (int c = 0; c < 5; c++) begin
      wr(12'h0f8, 32'h0020_0000 | (c == 0 ? 0 : c - 1));
      wr(12'h0f8, 32'h0020_0000 | c);
      wr(12'h0f8, 32'h0 | c);
      pulse(5'h01 << c, c == 0 ? 7'h7f : 7'h01);
      pulse(~(5'h01 << c), c == 0 ? 7'h00 : 7'h7e);
    end
    $display("done route");
  endtask
  task automatic t_hold;
    wr(12'h0f8, 32'h0020_0004);
    wr(12'h0f8, 32'h0020_0001);
    pulse(5'h03, 7'h7e);
    wr(12'h0f8, 32'h0fe0_0001);
    wr(12'h0f8, 32'hffff_ffff);
    rd(12'h0f8, 32'h0fff_ffff);
    chk({4'h0, domain_ctrl}, 32'h0fff_ffff);
    wr(12'h0f8, 32'h0fe0_0005);
    wr(12'h0f8, 32'h0000_0005);
    pulse(5'h1f, 7'h7e);
    rd(12'h200, 32'h0000_007e);
    wr(12'h0f8, 32'h0020_0005);
    wr(12'h0f8, 32'h0020_0001);
    wr(12'h0f8, 32'h0000_0001);
    pulse(5'h02, 7'h01);
    $display("done hold");
  endtask
  task automatic t_bad_addr;
    wr(12'h100, 32'h0fe0_0000);
    chk({30'h0, r}, {30'h0, clk_sel_pkg::RESP_DECERR});
    rd(12'h0f8, 32'h0000_0001);
    wstrb <= 4'h1;
    wr(12'h0f8, 32'hffff_ff01);
    wstrb <= 4'hf;
    chk({30'h0, r}, {30'h0, clk_sel_pkg::RESP_OKAY});
    rd(12'h0f8, 32'h0000_0001);
    rd(12'h104, 32'h0000_0000);
    chk({30'h0, rresp}, {30'h0, clk_sel_pkg::RESP_DECERR});
    $display("done bad address");
  endtask
  initial begin
    arst_n = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
    rready = 0; awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0;
    wstrb = 4'hf;
    pll_tick = 5'h00; fails = 0; tests_run = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1;
    @(posedge clk);
    t_reset;
    t_route;
    t_hold;
    t_bad_addr;
    finish_test;
  end
endmodule // interface_clock_source_select_tb_top
`default_nettype wire
